// ### logic/cbs_defines.vh
// constants for the core bus switch and bit unit
`ifndef CBS_DEFINES_VH
`define CBS_DEFINES_VH
`define CBS_W            16
`define CBS_AW           16
`define CBS_ZERO16       16'h0000
`define CBS_ONES16       16'hFFFF
`define CBS_HI_BYTE      16'hFF00
`define CBS_LO_BYTE      16'h00FF
`define CBS_PERIPH_BASE  16'hFFC0
`define CBS_SHORT_W      6
`define CBS_VEC_TOP      16'h007F
// bus source selects
`define CBS_SRC_NONE     2'h0
`define CBS_SRC_GDB      2'h1
`define CBS_SRC_PDB      2'h2
`define CBS_SRC_PGB      2'h3
// bit unit ops
`define CBS_OP_TEST      2'h0
`define CBS_OP_SET       2'h1
`define CBS_OP_CLR       2'h2
`define CBS_OP_INV       2'h3
// data memory access kinds
`define CBS_ACC_NONE     2'h0
`define CBS_ACC_RD       2'h1
`define CBS_ACC_WR       2'h2
`define CBS_ACC_DUAL     2'h3
`endif

// ### logic/cbs_fifo.v
// the result fifo module lives in cbs_switch.v, beside its only user

// ### logic/cbs_switch.v
// core bus switch matrix, memory access steering and bit manipulation unit
`timescale 1ns/10ps
`include "cbs_defines.vh"
module cbs_switch #(
  parameter W        = 16,
  parameter AW       = 16,
  parameter FIFO_D   = 4,
  parameter FIFO_AW  = 2,
  parameter NARROW_W = 4,
  parameter INT_TOP  = 16'h7FFF
) (
  input  wire          mclk,
  input  wire          rst,
  // transfer request from the core
  input  wire          req_valid,
  output wire          req_ready,
  input  wire [1:0]    src_sel,
  input  wire [1:0]    dst_sel,
  input  wire [1:0]    acc_kind,
  input  wire          short_mode,
  input  wire [5:0]    short_addr,
  input  wire [AW-1:0] first_addr,
  input  wire [AW-1:0] second_addr,
  input  wire [AW-1:0] fetch_addr,
  input  wire          fetch_en,
  input  wire          periph_sel,
  input  wire [W-1:0]  core_wdata,
  input  wire          narrow_rd,
  input  wire          bit_en,
  input  wire [1:0]    bit_op,
  input  wire          bit_branch,
  input  wire          bit_hi,
  input  wire [W-1:0]  bit_mask,
  // memory and peripheral side
  input  wire [W-1:0]  gdb_rdata,
  input  wire [W-1:0]  pdb_rdata,
  input  wire [W-1:0]  pgb_rdata,
  input  wire [W-1:0]  srd_rdata,
  output reg  [AW-1:0] first_data_address_bus,
  output reg  [AW-1:0] second_data_address_bus,
  output reg  [AW-1:0] program_address_bus,
  output reg  [W-1:0]  global_data_bus_out,
  output reg           global_data_bus_oe_n,
  output reg  [W-1:0]  program_data_bus_out,
  output reg           program_data_bus_oe_n,
  output reg  [W-1:0]  peripheral_global_bus_out,
  output reg           peripheral_global_bus_oe_n,
  output reg           mem_rd,
  output reg           mem_wr,
  output reg           mem_dual,
  output reg           mem_ext,
  output reg           fetch_vec,
  output reg           periph_rd,
  output reg           periph_wr,
  // results toward the core; res_data and res_valid through the fifo, the other outputs registered directly
  output wire [W-1:0]  res_data,
  output wire          res_valid,
  input  wire          res_ready,
  output reg  [W-1:0]  first_data_input_register,
  output reg           bit_all_set,
  output reg           bit_all_clr,
  output reg           bad_req
);
  reg  [W-1:0] sel_data;
  reg  [W-1:0] mask_eff;
  reg  [W-1:0] bit_res;
  reg  [AW-1:0] addr_eff;
  wire         fifo_ready;
  wire         take;
  wire         legal;
  reg  [W-1:0] res_word;
  reg          res_push;

  // pick the value on a source bus
  function [W-1:0] bus_pick;
    input [1:0]   sel;
    input [W-1:0] g;
    input [W-1:0] p;
    input [W-1:0] q;
    input [W-1:0] c;
    begin
      case (sel)
        `CBS_SRC_GDB: bus_pick = g;
        `CBS_SRC_PDB: bus_pick = p;
        `CBS_SRC_PGB: bus_pick = q;
        default:      bus_pick = c;
      endcase
    end
  endfunction

  // addresses above the internal range go off chip
  function addr_is_ext;
    input [AW-1:0] a;
    begin
      addr_is_ext = (a > INT_TOP);
    end
  endfunction

  // fold an address into the internal range; the second bus has no external path
  function [AW-1:0] to_internal;
    input [AW-1:0] a;
    begin
      to_internal = (a > INT_TOP) ? (a & INT_TOP) : a;
    end
  endfunction

  // stall when results cannot be buffered
  assign req_ready = fifo_ready;
  assign take      = req_valid & fifo_ready;
  // the source and destination must differ for a bus-to-bus move
  assign legal     = (src_sel == `CBS_SRC_NONE) || (dst_sel == `CBS_SRC_NONE) ||
                     (src_sel != dst_sel);

  always @* begin
    sel_data = bus_pick(src_sel, gdb_rdata, pdb_rdata, pgb_rdata, core_wdata);
    if (narrow_rd) begin
      sel_data = sel_data & ~(`CBS_ONES16 << NARROW_W);
    end
    // branch tests only see one byte of the mask
    if (bit_branch) begin
      mask_eff = bit_mask & (bit_hi ? `CBS_HI_BYTE : `CBS_LO_BYTE);
    end else begin
      mask_eff = bit_mask;
    end
    case (bit_op)
      `CBS_OP_SET: bit_res = sel_data | mask_eff;
      `CBS_OP_CLR: bit_res = sel_data & ~mask_eff;
      `CBS_OP_INV: bit_res = sel_data ^ mask_eff;
      default:     bit_res = sel_data;
    endcase
    // short direct mode maps onto the top 64 words
    if (short_mode) begin
      addr_eff = `CBS_PERIPH_BASE | {{(AW-`CBS_SHORT_W){1'b0}}, short_addr};
    end else begin
      addr_eff = first_addr;
    end
    res_word = bit_en ? bit_res : sel_data;
    res_push = take & legal & (bit_en | (src_sel != `CBS_SRC_NONE));
  end

  // results queue here so a slow consumer only stalls new requests
  cbs_fifo #(
    .WIDTH (W),
    .DEPTH (FIFO_D),
    .AW    (FIFO_AW)
  ) u_fifo (
    .mclk      (mclk),
    .rst       (rst),
    .in_data   (res_word),
    .in_valid  (res_push),
    .in_ready  (fifo_ready),
    .out_data  (res_data),
    .out_valid (res_valid),
    .out_ready (res_ready)
  );

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      first_data_address_bus     <= `CBS_ZERO16;
      second_data_address_bus    <= `CBS_ZERO16;
      program_address_bus        <= `CBS_ZERO16;
      global_data_bus_out        <= `CBS_ZERO16;
      global_data_bus_oe_n       <= 1'b1;
      program_data_bus_out       <= `CBS_ZERO16;
      program_data_bus_oe_n      <= 1'b1;
      peripheral_global_bus_out  <= `CBS_ZERO16;
      peripheral_global_bus_oe_n <= 1'b1;
      mem_rd                     <= 1'b0;
      mem_wr                     <= 1'b0;
      mem_dual                   <= 1'b0;
      mem_ext                    <= 1'b0;
      fetch_vec                  <= 1'b0;
      periph_rd                  <= 1'b0;
      periph_wr                  <= 1'b0;
      first_data_input_register  <= `CBS_ZERO16;
      bit_all_set                <= 1'b0;
      bit_all_clr                <= 1'b0;
      bad_req                    <= 1'b0;
    end else begin
      // fetch is independent of the data side, same cycle
      program_address_bus <= fetch_addr;
      fetch_vec <= fetch_en & (fetch_addr <= `CBS_VEC_TOP);
      global_data_bus_oe_n       <= 1'b1;
      program_data_bus_oe_n      <= 1'b1;
      peripheral_global_bus_oe_n <= 1'b1;
      mem_rd    <= 1'b0;
      mem_wr    <= 1'b0;
      mem_dual  <= 1'b0;
      periph_rd <= 1'b0;
      periph_wr <= 1'b0;
      bad_req   <= take & ~legal;
      if (take & legal) begin
        // drive the chosen destination bus with res_word; a write access below overrides the global bus and, with periph_sel, the peripheral bus
        case (dst_sel)
          `CBS_SRC_GDB: begin
            global_data_bus_out  <= res_word;
            global_data_bus_oe_n <= 1'b0;
          end
          `CBS_SRC_PDB: begin
            program_data_bus_out  <= res_word;
            program_data_bus_oe_n <= 1'b0;
          end
          `CBS_SRC_PGB: begin
            peripheral_global_bus_out  <= res_word;
            peripheral_global_bus_oe_n <= 1'b0;
          end
          default: begin
          end
        endcase
        // at most one memory access kind per cycle; none for the no-access kind
        case (acc_kind)
          `CBS_ACC_RD: begin
            first_data_address_bus <= addr_eff;
            mem_ext   <= addr_is_ext(addr_eff);
            mem_rd    <= ~periph_sel;
            periph_rd <= periph_sel;
          end
          `CBS_ACC_WR: begin
            first_data_address_bus <= addr_eff;
            mem_ext   <= addr_is_ext(addr_eff);
            mem_wr    <= ~periph_sel;
            periph_wr <= periph_sel;
            global_data_bus_out  <= periph_sel ? global_data_bus_out : core_wdata;
            global_data_bus_oe_n <= periph_sel;
            if (periph_sel) begin
              peripheral_global_bus_out  <= core_wdata;
              peripheral_global_bus_oe_n <= 1'b0;
            end
          end
          `CBS_ACC_DUAL: begin
            // second address bus never reaches external memory
            first_data_address_bus  <= addr_eff;
            second_data_address_bus <= to_internal(second_addr);
            mem_ext  <= addr_is_ext(addr_eff);
            mem_rd   <= 1'b1;
            mem_dual <= 1'b1;
            // read-only second bus feeds the input register
            first_data_input_register <= srd_rdata;
          end
          default: begin
            mem_ext <= 1'b0;
          end
        endcase
        if (bit_en & (bit_op == `CBS_OP_TEST)) begin
          bit_all_set <= ((sel_data & mask_eff) == mask_eff);
          bit_all_clr <= ((sel_data & mask_eff) == `CBS_ZERO16);
        end
      end
    end
  end
endmodule // cbs_switch

// result fifo; flags and read word are registered so the outputs come from flops
module cbs_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire             mclk,
  input  wire             rst,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0]    wr_q;
  reg [AW-1:0]    rd_q;
  reg [AW-1:0]    rd_d;
  reg [AW:0]      cnt_q;
  reg [AW:0]      cnt_d;
  reg             in_ready_q;
  reg             out_valid_q;
  reg [WIDTH-1:0] out_data_q;
  wire            push;
  wire            pop;
  assign in_ready  = in_ready_q;
  assign out_valid = out_valid_q;
  assign out_data  = out_data_q;
  assign push      = in_valid & in_ready_q;
  assign pop       = out_valid_q & out_ready;
  always @* begin
    rd_d = rd_q;
    if (pop) begin
      rd_d = (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
    end
    cnt_d = cnt_q;
    if (push & ~pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop & ~push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end
  always @(posedge mclk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
    // forward the incoming word when it lands in the slot read next
    if (push && (wr_q == rd_d)) begin
      out_data_q <= in_data;
    end else begin
      out_data_q <= mem_q[rd_d];
    end
  end
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      wr_q        <= {AW{1'b0}};
      rd_q        <= {AW{1'b0}};
      cnt_q       <= {(AW+1){1'b0}};
      in_ready_q  <= 1'b1;
      out_valid_q <= 1'b0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      rd_q        <= rd_d;
      cnt_q       <= cnt_d;
      // flags follow the next count, so they never lag the stored words
      in_ready_q  <= (cnt_d != DEPTH[AW:0]);
      out_valid_q <= (cnt_d != {(AW+1){1'b0}});
    end
  end
endmodule // cbs_fifo

// ### test/cbs_mem_model.sv
// data, program and peripheral memory model on the far side
`timescale 1ns/10ps
module cbs_mem_model (
  input  wire        mclk,
  input  wire [15:0] first_data_address_bus,
  input  wire [15:0] second_data_address_bus,
  input  wire [15:0] program_address_bus,
  input  wire [15:0] global_data_bus_out,
  input  wire        mem_wr,
  output wire [15:0] gdb_rdata,
  output wire [15:0] pdb_rdata,
  output wire [15:0] pgb_rdata,
  output wire [15:0] srd_rdata
);
  reg [15:0] mem [0:15];
  reg [15:0] spin_q = 16'hA5C3;
  integer    i;
  // known contents, so an unknown read word can never match by accident
  initial begin
    for (i = 0; i < 16; i = i + 1) begin
      mem[i] = 16'h3C00 + i;
    end
  end
  // read lines change every cycle so stale samples never match
  always @(posedge mclk) begin
    spin_q <= {spin_q[14:0], spin_q[15] ^ spin_q[13]};
    if (mem_wr)
      mem[first_data_address_bus[3:0]] <= global_data_bus_out;
  end
  assign gdb_rdata = mem[first_data_address_bus[3:0]] ^ spin_q;
  assign srd_rdata = mem[second_data_address_bus[3:0]] + spin_q;
  assign pdb_rdata = ~spin_q ^ program_address_bus;
  assign pgb_rdata = {spin_q[7:0], spin_q[15:8]};
endmodule // cbs_mem_model

// ### test/cbs_switch_properties.sv
// port assertions for the bus switch and bit unit
`timescale 1ns/10ps
module cbs_switch_checker (
  input wire        mclk,
  input wire        rst,
  input wire        req_valid,
  input wire        req_ready,
  input wire [1:0]  src_sel,
  input wire [1:0]  dst_sel,
  input wire [1:0]  acc_kind,
  input wire        short_mode,
  input wire [5:0]  short_addr,
  input wire        periph_sel,
  input wire        fetch_en,
  input wire [15:0] fetch_addr,
  input wire [15:0] gdb_rdata,
  input wire [15:0] srd_rdata,
  input wire [15:0] first_data_address_bus,
  input wire [15:0] program_address_bus,
  input wire [15:0] program_data_bus_out,
  input wire        program_data_bus_oe_n,
  input wire        mem_rd,
  input wire        mem_wr,
  input wire        mem_dual,
  input wire        fetch_vec,
  input wire [15:0] first_data_input_register,
  input wire [15:0] core_wdata,
  input wire        narrow_rd,
  input wire        bit_en,
  input wire [1:0]  bit_op,
  input wire        bit_branch,
  input wire        bit_hi,
  input wire [15:0] bit_mask,
  input wire [15:0] second_data_address_bus,
  input wire [15:0] peripheral_global_bus_out,
  input wire        peripheral_global_bus_oe_n,
  input wire        periph_wr,
  input wire        bit_all_set,
  input wire        bit_all_clr,
  input wire        bad_req
);
  // branch tests see only the chosen byte of the mask
  wire [15:0] mask_want = bit_branch ? (bit_mask & (bit_hi ? 16'hFF00 : 16'h00FF)) : bit_mask;
  // refused joins have no effect, so only legal takes count
  wire tk = req_valid && req_ready && (src_sel != dst_sel || src_sel == 2'h0);
  wire mk = tk && !periph_sel;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_bad_pulse: assert property (req_valid && req_ready && src_sel == dst_sel
    && src_sel != 2'h0 |=> bad_req) else $error("self join not flagged");
  a_join_nodelay: assert property (tk && src_sel == 2'h1 && dst_sel == 2'h2 && !bit_en &&
    !narrow_rd |=>
    !program_data_bus_oe_n && program_data_bus_out == $past(gdb_rdata)) else $error("join bad");
  a_vec_flag: assert property (1'b1 |=> fetch_vec ==
    ($past(fetch_en) && $past(fetch_addr) <= 16'h007F)) else $error("vector flag bad");
  a_fetch_addr: assert property (fetch_en |=>
    program_address_bus == $past(fetch_addr)) else $error("fetch address bad");
  a_dual_load: assert property (mk && acc_kind == 2'h3 |=> mem_dual &&
    first_data_input_register == $past(srd_rdata)) else $error("dual read bad");
  a_single_read: assert property (mk && acc_kind == 2'h1 |=>
    mem_rd && !mem_dual && !mem_wr) else $error("single read bad");
  a_no_rdwr: assert property (!(mem_rd && mem_wr))
    else $error("read and write together");
  a_short_addr: assert property (mk && short_mode && acc_kind == 2'h1 |=>
    first_data_address_bus == {10'h3FF, $past(short_addr)}) else $error("short address bad");
  a_bit_test: assert property (tk && bit_en && bit_op == 2'h0 && src_sel == 2'h0 &&
    !narrow_rd |=> bit_all_set == (($past(core_wdata) & $past(mask_want)) == $past(mask_want))
    && bit_all_clr == (($past(core_wdata) & $past(mask_want)) == 16'h0000))
    else $error("bit test bad");
  a_periph_write: assert property (tk && periph_sel && acc_kind == 2'h2 |=>
    periph_wr && !mem_wr && !peripheral_global_bus_oe_n &&
    peripheral_global_bus_out == $past(core_wdata)) else $error("peripheral write bad");
  a_second_int: assert property (tk && acc_kind == 2'h3 |=>
    !second_data_address_bus[15]) else $error("second address external");
  c_dual: cover property (mk && acc_kind == 2'h3);
  c_bit_test: cover property (tk && bit_en && bit_op == 2'h0);
  c_bad: cover property (bad_req);
  c_full: cover property (req_valid && !req_ready);
endmodule // cbs_switch_checker

bind cbs_switch cbs_switch_checker u_chk (.*);

// ### test/cbs_switch_tb.sv
// self-checking bench for the core bus switch
`timescale 1ns/10ps
module cbs_switch_tb;
  logic mclk = 0, rst = 1, req_valid = 0, short_mode = 0, fetch_en = 0, periph_sel = 0;
  logic narrow_rd = 0, bit_en = 0, bit_branch = 0, bit_hi = 0, res_ready = 0, hold = 1;
  logic [1:0] src_sel = 0, dst_sel = 0, acc_kind = 0, bit_op = 0;
  logic [5:0] short_addr = 0;
  logic [15:0] first_addr = 0, second_addr = 0, fetch_addr = 0, core_wdata = 0, bit_mask = 0;
  wire [15:0] gdb_rdata, pdb_rdata, pgb_rdata, srd_rdata, first_data_address_bus, res_data;
  wire [15:0] second_data_address_bus, program_address_bus, global_data_bus_out;
  wire [15:0] program_data_bus_out, peripheral_global_bus_out, first_data_input_register;
  wire req_ready, global_data_bus_oe_n, program_data_bus_oe_n, peripheral_global_bus_oe_n;
  wire mem_rd, mem_wr, mem_dual, mem_ext, fetch_vec, periph_rd, periph_wr, res_valid;
  wire bit_all_set, bit_all_clr, bad_req;
  logic [15:0] exp_q[$];
  logic [15:0] d, m;
  logic [31:0] r;
  integer failures = 0, comparisons = 0, seed = 19, cyc = 0, k;
  cbs_switch u_cbs_switch (.*);
  cbs_mem_model u_cbs_mem_model (.*);
  always #10 mclk = ~mclk;
  always @(posedge mclk) res_ready <= #1 !hold && ($random(seed) & 3) != 0;
  task chk(input string nm, input [15:0] seen, input [15:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task wrap_up;
    begin
      if (failures == 0 && comparisons > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  task send(input [1:0] s, input [1:0] t, input [1:0] a, input [1:0] o, input b, input n);
    begin
      @(posedge mclk);
      #1;
      {src_sel, dst_sel, acc_kind, bit_op, bit_en, narrow_rd} = {s, t, a, o, b, n};
      {short_mode, periph_sel, bit_branch, bit_hi} = $random(seed);
      {first_addr, second_addr} = $random(seed);
      {fetch_en, fetch_addr[7:0], short_addr} = $random(seed);
      {core_wdata, bit_mask} = $random(seed);
      req_valid = 1;
      @(negedge mclk);
      while (!req_ready) @(negedge mclk);
      d = s == 2'h0 ? core_wdata : s == 2'h1 ? gdb_rdata : s == 2'h2 ? pdb_rdata : pgb_rdata;
      m = !bit_branch ? bit_mask : bit_mask & (bit_hi ? 16'hFF00 : 16'h00FF);
      // a self join is refused and queues nothing
      if (s != 2'h0 && s == t)
        d = d;
      else if (b)
        exp_q.push_back(o == 2'h1 ? d | m : o == 2'h2 ? d & ~m : o == 2'h3 ? d ^ m : d);
      else if (s != 2'h0)
        exp_q.push_back(n ? d & 16'h000F : d);
    end
  endtask
  always @(posedge mclk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      failures = failures + 1;
      wrap_up;
    end
    if (!rst && res_valid && res_ready) begin
      if (exp_q.size() == 0)
        chk("result count", 16'h0001, 16'h0000);
      else
        chk("result", res_data, exp_q.pop_front());
    end
  end
  initial begin
    repeat (6) @(posedge mclk);
    #1;
    rst = 0;
    // fill the result queue with the far side stalled
    for (k = 0; k < 4; k = k + 1)
      send(2'h0, 2'h0, 2'h0, 2'(k % 3 + 1), 1'b1, 1'b0);
    @(posedge mclk);
    #1;
    req_valid = 0;
    chk("ready when full", {15'h0, req_ready}, 16'h0000);
    hold = 0;
    // narrow reads get no bit op, so reserved upper bits stay zero
    for (k = 0; k < 300; k = k + 1) begin
      r = $random(seed);
      send(r[1:0], r[3:2], r[5:4], r[9:8], r[6], r[7] & ~r[6]);
    end
    @(posedge mclk);
    #1;
    req_valid = 0;
    repeat (30) @(posedge mclk);
    chk("results left", exp_q.size(), 16'h0000);
    wrap_up;
  end
endmodule // cbs_switch_tb
